/* File: fcb_defines.vh */
`ifndef FCB_DEFINES_VH
`define FCB_DEFINES_VH
// ==========================================================
// Register offsets (byte addresses on the configuration port)
`define FCB_ADDR_W          12
`define FCB_OFS_THIRD       12'h41C
`define FCB_OFS_FOURTH      12'h41E
`define FCB_OFS_CENTER      12'h420
`define FCB_OFS_SIXTH       12'h423
`define FCB_OFS_SEVENTH     12'h425
`define FCB_OFS_CFG         12'h400
// ==========================================================
// Field layouts
`define FCB_DATA_W          24
`define FCB_SIDE_W          12
`define FCB_CTR_W           18
`define FCB_SIDE_RD_W       16
`define FCB_SIDE_MSB        11
`define FCB_CTR_MSB         17
`define FCB_CFG_W           8
`define FCB_CFG_MODE_LSB    0
`define FCB_CFG_MODE_MSB    1
`define FCB_CFG_SCW_LSB     2
`define FCB_CFG_SCW_MSB     4
`define FCB_CFG_MERGE_BIT   5
`define FCB_SCW_W           3
`define FCB_MODE_W          2
// ==========================================================
// Values
`define FCB_MODE_BYPASS     2'h0
`define FCB_MODE_ACTIVE     2'h2
`define FCB_SCW_MAX         3'h6
`define FCB_SIDE_RST        12'h000
`define FCB_CTR_RST         18'h00000
`define FCB_CFG_RST         8'h00
`define FCB_RD_ZERO         24'h000000
`endif

/* File: fcb_coef_reg.v */
`include "fcb_defines.vh"
// ==========================================================
// One coefficient register with masked readback
module fcb_coef_reg #(
  parameter                   WIDTH = `FCB_SIDE_W,
  parameter [`FCB_ADDR_W-1:0] ADDR  = 12'h000
) (
  input  wire                     i_mclk,
  input  wire                     i_rst_n,
  input  wire                     i_wr,
  input  wire [`FCB_ADDR_W-1:0]   i_addr,
  input  wire [`FCB_DATA_W-1:0]   i_wdata,
  output wire [WIDTH-1:0]         o_coef,
  output wire [`FCB_DATA_W-1:0]   o_rdback,
  output wire                     o_hit
);
  reg  [WIDTH-1:0] coef_reg;
  wire [WIDTH-1:0] coef_next;

  assign o_hit     = (i_addr == ADDR);
  // Upper reserved bits are dropped on write [R12]
  assign coef_next = (i_wr && o_hit) ? i_wdata[WIDTH-1:0] : coef_reg;

  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      coef_reg <= {WIDTH{1'h0}};
    else
      coef_reg <= coef_next;
  end

  assign o_coef   = coef_reg;
  // Top coefficient bit always reads as zero [R7]
  assign o_rdback = {{(`FCB_DATA_W-WIDTH+1){1'h0}}, coef_reg[WIDTH-2:0]};
endmodule // fcb_coef_reg

/* File: fcb_bank.v */
// Functional notes
// [R1] Outside taps hold 12-bit signed two's complement coefficients in bits 11:0.
// [R2] Bank feeds channel A filter in dual mode, merged filter in single mode.
// [R3] Offset 0x41C supplies the third tap coefficient.
// [R4] Offset 0x41E supplies fourth tap; offset 0x423 supplies sixth tap.
// [R5] Offset 0x420 holds the 18-bit signed center tap in bits 17:0.
// [R6] Offset 0x425 holds the seventh tap, 12-bit layout, reset zero.
// [R7] Readback of any coefficient returns zero in its top bit.
// [R8] Mode 0 bypasses the filter, mode 2 enables it; 1 and 3 reserved.
// [R9] Software sets merge whenever the converter runs single channel.
// [R10] Side weight 0..6 sets side LSB weight to 2^(field-16).
// [R11] Software changes configuration only while the serial link is disabled.
// [R12] Reserved upper coefficient bits are ignored when forming coefficients.
//
// Design decision made here: the address-and-strobe port.
`include "fcb_defines.vh"
module fcb_bank (
  input  wire                       i_mclk,
  input  wire                       i_reset_n,
  input  wire [`FCB_ADDR_W-1:0]     i_addr,
  input  wire [`FCB_DATA_W-1:0]     i_wdata,
  input  wire                       i_wr,
  input  wire                       i_rd,
  input  wire                       i_serial_link_enable,
  output reg  [`FCB_DATA_W-1:0]     o_rdata,
  output reg  signed [`FCB_SIDE_W-1:0] o_tap3,
  output reg  signed [`FCB_SIDE_W-1:0] o_tap4,
  output reg  signed [`FCB_CTR_W-1:0]  o_tap5,
  output reg  signed [`FCB_SIDE_W-1:0] o_tap6,
  output reg  signed [`FCB_SIDE_W-1:0] o_tap7,
  output reg  [`FCB_SCW_W-1:0]      o_fir_side_weight,
  output reg                        o_fir_enable,
  output reg                        o_fir_merge_channels,
  output reg                        o_cfg_locked_write
);
  // ==========================================================
  // Reset release
  // Asserts at once, releases two edges after the pin rises
  reg rst_s1_reg;
  reg rst_s2_reg;
  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_s1_reg <= 1'h0;
      rst_s2_reg <= 1'h0;
    end
    else
    begin
      rst_s1_reg <= 1'h1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire rst_n = rst_s2_reg;

  // ==========================================================
  // Link enable synchroniser
  // Level from another domain; only the second stage is read
  reg link_s1_reg;
  reg link_s2_reg;
  always @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_s1_reg <= 1'h0;
      link_s2_reg <= 1'h0;
    end
    else
    begin
      link_s1_reg <= i_serial_link_enable;
      link_s2_reg <= link_s1_reg;
    end
  end

  // ==========================================================
  // Coefficient registers
  // Reserved upper bits never reach a register [R12]
  wire [`FCB_SIDE_W-1:0] c3;
  wire [`FCB_SIDE_W-1:0] c4;
  wire [`FCB_CTR_W-1:0]  c5;
  wire [`FCB_SIDE_W-1:0] c6;
  wire [`FCB_SIDE_W-1:0] c7;

  wire [`FCB_DATA_W-1:0] r3;
  wire [`FCB_DATA_W-1:0] r4;
  wire [`FCB_DATA_W-1:0] r5;
  wire [`FCB_DATA_W-1:0] r6;
  wire [`FCB_DATA_W-1:0] r7;

  wire                   h3;
  wire                   h4;
  wire                   h5;
  wire                   h6;
  wire                   h7;

  // Third tap
  fcb_coef_reg #(
    .WIDTH    (`FCB_SIDE_W),
    .ADDR     (`FCB_OFS_THIRD)
  ) u_tap3 ( // [R3]
    .i_mclk   (i_mclk),
    .i_rst_n  (rst_n),
    .i_wr     (i_wr),
    .i_addr   (i_addr),
    .i_wdata  (i_wdata),
    .o_coef   (c3),
    .o_rdback (r3),
    .o_hit    (h3)
  );

  // Fourth tap
  fcb_coef_reg #(
    .WIDTH    (`FCB_SIDE_W),
    .ADDR     (`FCB_OFS_FOURTH)
  ) u_tap4 ( // [R4]
    .i_mclk   (i_mclk),
    .i_rst_n  (rst_n),
    .i_wr     (i_wr),
    .i_addr   (i_addr),
    .i_wdata  (i_wdata),
    .o_coef   (c4),
    .o_rdback (r4),
    .o_hit    (h4)
  );

  // Center tap, wider coefficient
  fcb_coef_reg #(
    .WIDTH    (`FCB_CTR_W),
    .ADDR     (`FCB_OFS_CENTER)
  ) u_tap5 ( // [R5]
    .i_mclk   (i_mclk),
    .i_rst_n  (rst_n),
    .i_wr     (i_wr),
    .i_addr   (i_addr),
    .i_wdata  (i_wdata),
    .o_coef   (c5),
    .o_rdback (r5),
    .o_hit    (h5)
  );

  // Sixth tap
  fcb_coef_reg #(
    .WIDTH    (`FCB_SIDE_W),
    .ADDR     (`FCB_OFS_SIXTH)
  ) u_tap6 ( // [R4]
    .i_mclk   (i_mclk),
    .i_rst_n  (rst_n),
    .i_wr     (i_wr),
    .i_addr   (i_addr),
    .i_wdata  (i_wdata),
    .o_coef   (c6),
    .o_rdback (r6),
    .o_hit    (h6)
  );

  // Seventh tap
  fcb_coef_reg #(
    .WIDTH    (`FCB_SIDE_W),
    .ADDR     (`FCB_OFS_SEVENTH)
  ) u_tap7 ( // [R6]
    .i_mclk   (i_mclk),
    .i_rst_n  (rst_n),
    .i_wr     (i_wr),
    .i_addr   (i_addr),
    .i_wdata  (i_wdata),
    .o_coef   (c7),
    .o_rdback (r7),
    .o_hit    (h7)
  );

  // ==========================================================
  // Filter configuration register
  reg  [`FCB_CFG_W-1:0] cfg_reg;
  reg  [`FCB_CFG_W-1:0] cfg_next;
  // Top two bits are stored and read back but drive nothing
  wire                  cfg_hit  = (i_addr == `FCB_OFS_CFG);
  wire                  cfg_wr   = i_wr & cfg_hit;
  wire [`FCB_SCW_W-1:0] scw_wr   = i_wdata[`FCB_CFG_SCW_MSB:`FCB_CFG_SCW_LSB];
  wire                  scw_over = (scw_wr > `FCB_SCW_MAX);

  always @*
  begin
    cfg_next = cfg_reg;
    if (cfg_wr)
    begin
      cfg_next = i_wdata[`FCB_CFG_W-1:0];
      // Side weight saturates at its top legal value
      if (scw_over) // [R10]
        cfg_next[`FCB_CFG_SCW_MSB:`FCB_CFG_SCW_LSB] = `FCB_SCW_MAX;
    end
  end

  always @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_reg <= `FCB_CFG_RST;
    else
      cfg_reg <= cfg_next;
  end

  wire [`FCB_MODE_W-1:0] mode = cfg_reg[`FCB_CFG_MODE_MSB:`FCB_CFG_MODE_LSB];
  wire any_hit = h3 | h4 | h5 | h6 | h7 | cfg_hit;

  // ==========================================================
  // Read data, one cycle after the strobe
  wire [`FCB_DATA_W-1:0] rcfg = {{(`FCB_DATA_W-`FCB_CFG_W){1'h0}}, cfg_reg};
  reg  [`FCB_DATA_W-1:0] rd_sel;
  reg  [`FCB_DATA_W-1:0] rdata_next;

  // Unmapped addresses read as zero
  always @*
  begin
    rd_sel = `FCB_RD_ZERO;
    if (h3)
      rd_sel = r3; // [R7]
    else if (h4)
      rd_sel = r4; // [R7]
    else if (h5)
      rd_sel = r5; // [R7]
    else if (h6)
      rd_sel = r6; // [R7]
    else if (h7)
      rd_sel = r7; // [R7]
    else if (cfg_hit)
      rd_sel = rcfg;
  end

  // Bus idles at zero outside the answer cycle
  always @*
  begin
    rdata_next = `FCB_RD_ZERO;
    if (i_rd)
      rdata_next = rd_sel;
  end

  always @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      o_rdata <= `FCB_RD_ZERO;
    else
      o_rdata <= rdata_next;
  end

  // ==========================================================
  // Filter tap outputs
  // Same tap order for dual channel A and merged single filter
  wire signed [`FCB_SIDE_W-1:0] tap3_next = $signed(c3);
  wire signed [`FCB_SIDE_W-1:0] tap4_next = $signed(c4);
  wire signed [`FCB_CTR_W-1:0]  tap5_next = $signed(c5);
  wire signed [`FCB_SIDE_W-1:0] tap6_next = $signed(c6);
  wire signed [`FCB_SIDE_W-1:0] tap7_next = $signed(c7);

  always @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_tap3 <= `FCB_SIDE_RST;
      o_tap4 <= `FCB_SIDE_RST;
      o_tap5 <= `FCB_CTR_RST;
      o_tap6 <= `FCB_SIDE_RST;
      o_tap7 <= `FCB_SIDE_RST;
    end
    else
    begin
      o_tap3 <= tap3_next; // [R1] [R2]
      o_tap4 <= tap4_next; // [R1]
      o_tap5 <= tap5_next; // [R5]
      o_tap6 <= tap6_next; // [R1]
      o_tap7 <= tap7_next; // [R6]
    end
  end

  // ==========================================================
  // Filter configuration outputs
  wire [`FCB_SCW_W-1:0] weight_next = cfg_reg[`FCB_CFG_SCW_MSB:`FCB_CFG_SCW_LSB];
  // Reserved mode codes leave the filter bypassed
  wire                  enable_next = (mode == `FCB_MODE_ACTIVE);
  wire                  merge_next  = cfg_reg[`FCB_CFG_MERGE_BIT];

  always @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_fir_side_weight    <= {`FCB_SCW_W{1'h0}};
      o_fir_enable         <= 1'h0;
      o_fir_merge_channels <= 1'h0;
    end
    else
    begin
      o_fir_side_weight    <= weight_next; // [R10]
      o_fir_enable         <= enable_next; // [R8]
      o_fir_merge_channels <= merge_next;  // [R2]
    end
  end

  // ==========================================================
  // Write-while-link-enabled status
  // Sticky until reset so software can spot an unsafe update
  wire any_wr      = i_wr & any_hit;
  wire locked_set  = any_wr & link_s2_reg;
  wire locked_next = o_cfg_locked_write | locked_set;

  always @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      o_cfg_locked_write <= 1'h0;
    else
      o_cfg_locked_write <= locked_next; // [R11]
  end
endmodule // fcb_bank

/* File: fcb_bank_assertions.sv */
// ==========================================
// Checker on the top-level ports
module fcb_chk (
  input logic               i_mclk,
  input logic               i_reset_n,
  input logic [11:0]        i_addr,
  input logic [23:0]        i_wdata,
  input logic               i_wr,
  input logic               i_rd,
  input logic [23:0]        o_rdata,
  input logic signed [11:0] o_tap3,
  input logic signed [11:0] o_tap4,
  input logic signed [17:0] o_tap5,
  input logic signed [11:0] o_tap6,
  input logic signed [11:0] o_tap7,
  input logic [2:0]         o_fir_side_weight
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  tap3_load_a: assert property (i_wr && i_addr == 12'h41C |-> ##2 o_tap3 == $past(i_wdata[11:0], 2))
    else $error("tap3 wrong");
  tap4_load_a: assert property (i_wr && i_addr == 12'h41E |-> ##2 o_tap4 == $past(i_wdata[11:0], 2))
    else $error("tap4 wrong");
  center_load_a: assert property (i_wr && i_addr == 12'h420 |-> ##2 o_tap5 == $past(i_wdata[17:0], 2))
    else $error("center wrong");
  tap6_load_a: assert property (i_wr && i_addr == 12'h423 |-> ##2 o_tap6 == $past(i_wdata[11:0], 2))
    else $error("tap6 wrong");
  tap7_load_a: assert property (i_wr && i_addr == 12'h425 |-> ##2 o_tap7 == $past(i_wdata[11:0], 2))
    else $error("tap7 wrong");
  side_msb_a: assert property (i_rd && i_addr != 12'h420 |=> o_rdata[23:11] == 13'h0000)
    else $error("side readback top bits");
  center_msb_a: assert property (i_rd && i_addr == 12'h420 |=> o_rdata[23:17] == 7'h00)
    else $error("center readback top bits");
  rdata_idle_a: assert property (!i_rd |=> o_rdata == 24'h000000)
    else $error("read data outside read");
  weight_range_a: assert property (o_fir_side_weight <= 3'h6)
    else $error("side weight above 6");
endmodule // fcb_chk
bind fcb_bank fcb_chk u_chk (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_tap3(o_tap3), .o_tap4(o_tap4), .o_tap5(o_tap5),
  .o_tap6(o_tap6), .o_tap7(o_tap7), .o_fir_side_weight(o_fir_side_weight));

/* File: fcb_bank_tb_top.sv */
module fcb_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic               i_mclk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0, i_serial_link_enable = 0, rd_d = 0;
  logic [11:0]        i_addr = 12'h000;
  logic [23:0]        i_wdata = 24'h000000, o_rdata, d, t[5], q[$];
  logic signed [11:0] o_tap3, o_tap4, o_tap6, o_tap7;
  logic signed [17:0] o_tap5;
  logic [2:0]         o_fir_side_weight;
  logic               o_fir_enable, o_fir_merge_channels, o_cfg_locked_write;
  logic [11:0]        ad[5] = '{12'h41C, 12'h41E, 12'h420, 12'h423, 12'h425};
  int                 fails = 0, compares = 0, cyc = 0, seed = 4;
  fcb_bank DUT (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_serial_link_enable(i_serial_link_enable), .o_rdata(o_rdata), .o_tap3(o_tap3),
    .o_tap4(o_tap4), .o_tap5(o_tap5), .o_tap6(o_tap6), .o_tap7(o_tap7), .o_fir_side_weight(o_fir_side_weight),
    .o_fir_enable(o_fir_enable), .o_fir_merge_channels(o_fir_merge_channels),
    .o_cfg_locked_write(o_cfg_locked_write));
  always #10 i_mclk = ~i_mclk;
  // ==========================================
  // Compare, bus cycle, verdict
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    compares++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [23:0] v, input logic [23:0] e);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= v;
    if (r) q.push_back(e);
    @(posedge i_mclk);
  endtask
  task automatic give_verdict();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================
  // Read data monitor and hang guard
  always @(posedge i_mclk)
  begin
    rd_d <= i_rd;
    cyc <= cyc + 1;
    if (rd_d) chk(o_rdata, q.pop_front());
    if (cyc == 3000)
    begin
      fails++;
      give_verdict();
    end
  end
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (6) @(posedge i_mclk);
    i_reset_n <= 1;
    repeat (3) @(posedge i_mclk);
    for (int i = 0; i < 5; i++) bus(0, 1, ad[i], 0, 0);
    for (int r = 0; r < 4; r++)
    begin
      for (int i = 0; i < 5; i++)
      begin
        d = 24'($random(seed));
        d[17] = r[0];
        d[11] = r[0];
        t[i] = d;
        bus(1, 0, ad[i], d, 0);
      end
      bus(1, 0, 12'h41D, 24'hFFFFFF, 0);
      bus(0, 1, 12'h41D, 0, 0);
      for (int i = 0; i < 5; i++) bus(0, 1, ad[i], 0, t[i] & (i == 2 ? 24'h01FFFF : 24'h0007FF));
      repeat (2) bus(0, 0, 0, 0, 0);
      chk({12'h000, o_tap3}, t[0] & 24'h000FFF);
      chk({12'h000, o_tap4}, t[1] & 24'h000FFF);
      chk({6'h00, o_tap5}, t[2] & 24'h03FFFF);
      chk({12'h000, o_tap6}, t[3] & 24'h000FFF);
      chk({12'h000, o_tap7}, t[4] & 24'h000FFF);
    end
    for (int m = 0; m < 8; m++)
    begin
      bus(1, 0, 12'h400, {16'h0000, m[1:0], m[0], m[2:0], m[1:0]}, 0);
      bus(0, 1, 12'h400, 0, {16'h0000, m[1:0], m[0], (m > 6 ? 3'h6 : m[2:0]), m[1:0]});
      repeat (3) bus(0, 0, 0, 0, 0);
      chk({23'h000000, o_fir_enable}, {23'h000000, m[1:0] == 2'h2});
      chk({21'h000000, o_fir_side_weight}, m > 6 ? 24'h000006 : 24'(m));
      chk({23'h000000, o_fir_merge_channels}, {23'h000000, m[0]});
    end
    chk({23'h000000, o_cfg_locked_write}, 24'h000000);
    i_serial_link_enable <= 1;
    repeat (3) bus(0, 0, 0, 0, 0);
    bus(1, 0, ad[0], 24'h000005, 0);
    repeat (3) bus(0, 0, 0, 0, 0);
    chk({23'h000000, o_cfg_locked_write}, 24'h000001);
    chk({12'h000, o_tap3}, 24'h000005);
    i_reset_n <= 0;
    repeat (2) bus(0, 0, 0, 0, 0);
    i_reset_n <= 1;
    repeat (3) bus(0, 0, 0, 0, 0);
    chk({23'h000000, o_cfg_locked_write}, 24'h000000);
    chk({12'h000, o_tap3}, 24'h000000);
    give_verdict();
  end
endmodule // fcb_bank_tb_top
